// ==== hdl/ssx_pkg.sv ====
package ssx_pkg;
    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_TX_BYTE_COUNT = 8'h77;
    localparam logic [7:0] IDX_TX_SEQ = 8'h78;
    localparam logic [7:0] IDX_RX_ECHO = 8'h79;
    localparam logic [7:0] IDX_STAT_CLR = 8'h7A;
    localparam logic [7:0] IDX_FLUSH = 8'h7B;
    localparam logic [7:0] IDX_PAYLOAD = 8'h7C;
    localparam logic [7:0] IDX_PAYLOAD_GO = 8'h7D;
    localparam logic [7:0] IDX_ERROR_WORD = 8'h7F;
    localparam logic [7:0] IDX_HDR_SEL = 8'h80;
    localparam logic [7:0] IDX_RX_DATA_LO = 8'h75;
    localparam logic [7:0] IDX_PAYLOAD_HI = 8'h90;
    localparam logic [7:0] IDX_RX_DATA_HI = 8'h91;
    localparam logic [7:0] IDX_RX_STATUS = 8'h92;
    // Field positions
    localparam int FLUSH_TX_BIT = 0;
    localparam int FLUSH_RX_BIT = 1;
    localparam int DIAG_PARAM_BIT = 3;
    localparam int DIAG_HW_BIT = 4;
    localparam int DIAG_HSHAKE_BIT = 5;
    localparam int DIAG_FRAME_BIT = 6;
    localparam int DIAG_OVFL_BIT = 7;
    localparam int RXS_LOSS_BIT = 2;
    localparam int RXS_STAT_BIT = 7;
    // User bytes per segment for each header size
    localparam logic [3:0] USER_BYTES_HDR1 = 4'h7;
    localparam logic [3:0] USER_BYTES_HDR2 = 4'h6;
    // Reset values
    localparam logic [1:0] SEQ_RESET = 2'h0;
    localparam logic [31:0] WORD_RESET = 32'h00000000;
endpackage

// ==== hdl/ssx_seq_track.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssx_seq_track (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic step,
    input wire logic [1:0] seq_in,
    output logic [1:0] expected,
    output logic lost
);
    import ssx_pkg::*;
    logic [1:0] exp_q, exp_d; // Next value the sequence should carry

    // Any break in the two-bit cycle means segments went missing
    always_comb begin
        exp_d = exp_q;
        lost = 1'b0;
        if (step) begin
            lost = (seq_in != exp_q);
            // Resynchronise so one gap reports once
            exp_d = seq_in + 2'h1;
        end
    end

    // Register the expected count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exp_q <= SEQ_RESET;
        end else begin
            exp_q <= exp_d;
        end
    end

    assign expected = exp_q;
endmodule
`default_nettype wire

// ==== hdl/ssx_diag_word.sv ====
`timescale 1ns/1ps
`default_nettype none
module ssx_diag_word (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic err_param,
    input wire logic err_hw,
    input wire logic err_handshake,
    input wire logic err_frame,
    input wire logic err_overflow,
    output logic [15:0] diag
);
    import ssx_pkg::*;
    logic [15:0] diag_q, diag_d; // Registered error report

    // Low byte carries messages, reserved bits stay zero
    always_comb begin
        diag_d = 16'h0000;
        diag_d[DIAG_PARAM_BIT] = err_param;
        diag_d[DIAG_HW_BIT] = err_hw;
        diag_d[DIAG_HSHAKE_BIT] = err_handshake;
        diag_d[DIAG_FRAME_BIT] = err_frame;
        diag_d[DIAG_OVFL_BIT] = err_overflow;
    end

    // Register the word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diag_q <= 16'h0000;
        end else begin
            diag_q <= diag_d;
        end
    end

    assign diag = diag_q;
endmodule
`default_nettype wire

// ==== hdl/ssx_exchange.sv ====
// Behaviour
// - transmit sequence travels with every segment
// - sequence break flags lost segments
// - falling clear bit clears status flag
// - clear bit low ignores count changes
// - flushes accepted while clear bit low; code also needs it low the cycle before
// - flushes refused while clear bit high
// - bit 0 flushes transmit, bit 1 receive
// - payload-go write loads and starts transmission
// - diagnostics low byte, reserved bits zero
// - bit 3 reports parameter error
// - bit 4 reports hardware failure
// - bit 5 reports handshake error
// - bit 6 reports framing error
// - bit 7 reports receive overflow
// - mode 0 one-byte header, seven bytes
// - mode 1 two-byte header, six bytes
// - received bytes delivered in receive field
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ssx_exchange #(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_seg_valid,
    input wire logic [55:0] rx_seg_data,
    input wire logic [3:0] rx_seg_count,
    output logic rx_seg_ready,
    output logic tx_seg_valid,
    output logic [55:0] tx_seg_data,
    output logic [3:0] tx_seg_count,
    output logic [1:0] tx_seg_seq,
    output logic tx_flush,
    output logic rx_flush,
    input wire logic err_param,
    input wire logic err_hw,
    input wire logic err_handshake,
    input wire logic err_frame,
    input wire logic err_overflow
);
    import ssx_pkg::*;

    // Decode slices the address above bit 9, so bit 10 must exist
    if (ADDR_W < 11 || ADDR_W > 16) begin : g_bad_addr_w
        $error("ADDR_W must lie between 11 and 16");
    end

    // Register decode, shared by read and write paths
    function automatic logic [3:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [7:0] idx;
        idx = a[9:2];
        if (a[1:0] != 2'h0 || a[ADDR_W-1:10] != '0) begin
            return 4'hF;
        end
        unique case (idx)
            IDX_TX_BYTE_COUNT: return 4'h0;
            IDX_TX_SEQ: return 4'h1;
            IDX_RX_ECHO: return 4'h2;
            IDX_STAT_CLR: return 4'h3;
            IDX_FLUSH: return 4'h4;
            IDX_PAYLOAD: return 4'h5;
            IDX_PAYLOAD_GO: return 4'h6;
            IDX_ERROR_WORD: return 4'h7;
            IDX_HDR_SEL: return 4'h8;
            IDX_RX_DATA_LO: return 4'h9;
            IDX_PAYLOAD_HI: return 4'hA;
            IDX_RX_DATA_HI: return 4'hB;
            IDX_RX_STATUS: return 4'hC;
            default: return 4'hF;
        endcase
    endfunction

    // Bus state
    logic pready_q, pready_d; // High through every access phase
    logic pslverr_q, pslverr_d; // Unmapped or wrong-direction access
    logic [31:0] prdata_q, prdata_d; // Read data captured at setup
    // Control registers
    logic [3:0] tx_cnt_q, tx_cnt_d; // Valid user bytes of next segment
    logic [1:0] tx_seq_q, tx_seq_d; // Sequence sent with next segment
    logic [1:0] rx_echo_q, rx_echo_d; // Last acknowledge from controller
    logic clr_q, clr_d; // Status-clear request bit
    logic clr_prev_q; // Clear bit one cycle ago, for edges
    logic hdr_q, hdr_d; // Header size select
    logic [55:0] pay_q, pay_d; // Transmit payload
    // Segment and status state
    logic tx_valid_q, tx_valid_d; // One-cycle launch strobe
    logic [55:0] tx_data_q, tx_data_d;
    logic [3:0] tx_ocnt_q, tx_ocnt_d;
    logic [1:0] tx_oseq_q, tx_oseq_d;
    logic txf_q, txf_d, rxf_q, rxf_d; // Flush strobes
    logic rx_free_q, rx_free_d; // Receive field may take a segment
    logic [55:0] rx_data_q, rx_data_d;
    logic [3:0] rx_cnt_q, rx_cnt_d;
    logic [1:0] rx_seq_q, rx_seq_d; // Sequence sent with input segment
    logic stat_q, stat_d; // Status flag of process input
    logic loss_q, loss_d; // Sticky lost-segment indication
    // Helpers
    logic [15:0] diag; // Error report word
    logic [1:0] tx_expected; // Next expected transmit sequence
    logic seq_lost; // Sequence break on this launch
    logic wr_en, rd_setup; // Bus strobes
    logic [3:0] wsel, rsel; // Decoded selects
    logic [3:0] user_max; // Bytes allowed by header size
    logic flush_ok; // Flush window open
    logic go; // Launch this cycle

    assign wr_en = psel && penable && pready_q && pwrite;
    assign rd_setup = psel && !penable;
    assign wsel = reg_sel(paddr);
    assign rsel = wsel;
    assign user_max = hdr_q ? USER_BYTES_HDR2 : USER_BYTES_HDR1;
    // Clear bit must be low now and low last cycle; no flush on falling edge
    assign flush_ok = !clr_q && !clr_prev_q;
    assign go = wr_en && (wsel == 4'h6);

    ssx_seq_track u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .step(go),
        .seq_in(tx_seq_q),
        .expected(tx_expected),
        .lost(seq_lost)
    );

    ssx_diag_word u_diag (
        .pclk(pclk),
        .presetn(presetn),
        .err_param(err_param),
        .err_hw(err_hw),
        .err_handshake(err_handshake),
        .err_frame(err_frame),
        .err_overflow(err_overflow),
        .diag(diag)
    );

    // Bus answer: data and ready prepared in the setup cycle
    always_comb begin
        pready_d = rd_setup;
        pslverr_d = 1'b0;
        prdata_d = WORD_RESET;
        if (rd_setup) begin
            // Payload-go is write-only, error word and receive fields read-only
            pslverr_d = (rsel == 4'hF) || (pwrite && (rsel == 4'h7 || rsel == 4'h9
                        || rsel == 4'hB || rsel == 4'hC)) || (!pwrite && rsel == 4'h6);
            if (!pwrite) begin
                unique case (rsel)
                    4'h0: prdata_d = {28'h0, tx_cnt_q};
                    4'h1: prdata_d = {30'h0, tx_seq_q};
                    4'h2: prdata_d = {30'h0, rx_echo_q};
                    4'h3: prdata_d = {31'h0, clr_q};
                    4'h4: prdata_d = WORD_RESET;
                    4'h5: prdata_d = pay_q[31:0];
                    4'h7: prdata_d = {16'h0, diag};
                    4'h8: prdata_d = {31'h0, hdr_q};
                    4'h9: prdata_d = rx_data_q[31:0];
                    4'hA: prdata_d = {8'h0, pay_q[55:32]};
                    4'hB: prdata_d = {8'h0, rx_data_q[55:32]};
                    // Diagnostics join process input only with two-byte header
                    4'hC: prdata_d = {12'h0, rx_cnt_q, hdr_q ? diag[7:0] : 8'h00,
                                      stat_q, 4'h0, loss_q, rx_seq_q};
                    default: prdata_d = WORD_RESET;
                endcase
            end
        end
    end

    // Control register writes
    always_comb begin
        tx_cnt_d = tx_cnt_q;
        tx_seq_d = tx_seq_q;
        rx_echo_d = rx_echo_q;
        clr_d = clr_q;
        hdr_d = hdr_q;
        pay_d = pay_q;
        txf_d = 1'b0;
        rxf_d = 1'b0;
        if (wr_en) begin
            unique case (wsel)
                // Counts and acknowledge only change while clear bit is high
                4'h0: if (clr_q) tx_cnt_d = pwdata[3:0];
                4'h1: if (clr_q) tx_seq_d = pwdata[1:0];
                4'h2: if (clr_q) rx_echo_d = pwdata[1:0];
                4'h3: clr_d = pwdata[0];
                4'h4: begin
                    if (flush_ok) begin
                        txf_d = pwdata[FLUSH_TX_BIT];
                        rxf_d = pwdata[FLUSH_RX_BIT];
                    end
                end
                4'h5: pay_d[31:0] = pwdata;
                4'h6: pay_d[31:0] = pwdata;
                4'h8: hdr_d = pwdata[0];
                4'hA: pay_d[55:32] = pwdata[23:0];
                default: pay_d = pay_q;
            endcase
        end
    end

    // Segment launch, capture and status
    always_comb begin
        tx_valid_d = go;
        tx_data_d = tx_data_q;
        tx_ocnt_d = tx_ocnt_q;
        tx_oseq_d = tx_oseq_q;
        rx_free_d = rx_free_q;
        rx_data_d = rx_data_q;
        rx_cnt_d = rx_cnt_q;
        rx_seq_d = rx_seq_q;
        stat_d = stat_q;
        loss_d = loss_q;
        if (go) begin
            tx_data_d = {pay_q[55:32], pwdata};
            tx_ocnt_d = (tx_cnt_q > user_max) ? user_max : tx_cnt_q;
            tx_oseq_d = tx_seq_q;
        end
        // Controller acknowledge frees the receive field
        if (wr_en && wsel == 4'h2 && clr_q && !rx_free_q && pwdata[1:0] == rx_seq_q) begin
            rx_free_d = 1'b1;
        end
        if (rx_seg_valid && rx_free_q) begin
            rx_data_d = rx_seg_data;
            if (hdr_q) begin
                rx_data_d[55:48] = 8'h00;
            end
            rx_cnt_d = (rx_seg_count > user_max) ? user_max : rx_seg_count;
            rx_seq_d = rx_seq_q + 2'h1;
            rx_free_d = 1'b0;
        end
        // Falling clear bit clears the flag, but a new event wins
        if (clr_prev_q && !clr_q) begin
            stat_d = 1'b0;
            loss_d = 1'b0;
        end
        if (seq_lost) begin
            loss_d = 1'b1;
        end
        if (seq_lost || diag[7:3] != 5'h00) begin
            stat_d = 1'b1;
        end
    end

    // Register every group
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= WORD_RESET;
            tx_cnt_q <= 4'h0;
            tx_seq_q <= SEQ_RESET;
            rx_echo_q <= SEQ_RESET;
            clr_q <= 1'b0;
            clr_prev_q <= 1'b0;
            hdr_q <= 1'b0;
            pay_q <= 56'h0;
            txf_q <= 1'b0;
            rxf_q <= 1'b0;
            tx_valid_q <= 1'b0;
            tx_data_q <= 56'h0;
            tx_ocnt_q <= 4'h0;
            tx_oseq_q <= SEQ_RESET;
            rx_free_q <= 1'b1;
            rx_data_q <= 56'h0;
            rx_cnt_q <= 4'h0;
            rx_seq_q <= SEQ_RESET;
            stat_q <= 1'b0;
            loss_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            tx_cnt_q <= tx_cnt_d;
            tx_seq_q <= tx_seq_d;
            rx_echo_q <= rx_echo_d;
            clr_q <= clr_d;
            clr_prev_q <= clr_q;
            hdr_q <= hdr_d;
            pay_q <= pay_d;
            txf_q <= txf_d;
            rxf_q <= rxf_d;
            tx_valid_q <= tx_valid_d;
            tx_data_q <= tx_data_d;
            tx_ocnt_q <= tx_ocnt_d;
            tx_oseq_q <= tx_oseq_d;
            rx_free_q <= rx_free_d;
            rx_data_q <= rx_data_d;
            rx_cnt_q <= rx_cnt_d;
            rx_seq_q <= rx_seq_d;
            stat_q <= stat_d;
            loss_q <= loss_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign rx_seg_ready = rx_free_q;
    assign tx_seg_valid = tx_valid_q;
    assign tx_seg_data = tx_data_q;
    assign tx_seg_count = tx_ocnt_q;
    assign tx_seg_seq = tx_oseq_q;
    assign tx_flush = txf_q;
    assign rx_flush = rxf_q;

    // Checks
    property p_launch;
        @(posedge pclk) disable iff (!presetn)
        go |=> tx_seg_valid && tx_seg_seq == $past(tx_seq_q) && tx_seg_data[31:0] == $past(pwdata);
    endproperty
    a_launch: assert property (p_launch) else $error("launch missed");

    property p_no_flush_high;
        @(posedge pclk) disable iff (!presetn)
        (clr_q || clr_prev_q) |=> !tx_flush && !rx_flush;
    endproperty
    a_no_flush_high: assert property (p_no_flush_high) else $error("flush while refused");

    property p_flush_map;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && wsel == 4'h4 && flush_ok) |=> tx_flush == $past(pwdata[0])
            && rx_flush == $past(pwdata[1]);
    endproperty
    a_flush_map: assert property (p_flush_map) else $error("flush bits swapped");

    property p_ignore_seq;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && wsel == 4'h1 && !clr_q) |=> $stable(tx_seq_q);
    endproperty
    a_ignore_seq: assert property (p_ignore_seq) else $error("sequence changed while low");

    property p_stat_clear;
        @(posedge pclk) disable iff (!presetn)
        (clr_prev_q && !clr_q && !seq_lost && diag[7:3] == 5'h00) |=> !stat_q;
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");

    property p_loss;
        @(posedge pclk) disable iff (!presetn)
        (go && tx_seq_q != tx_expected) |=> loss_q && stat_q;
    endproperty
    a_loss: assert property (p_loss) else $error("loss not flagged");

    property p_rx_seq;
        @(posedge pclk) disable iff (!presetn)
        (rx_seg_valid && rx_seg_ready) |=> rx_seq_q == $past(rx_seq_q) + 2'h1 && !rx_seg_ready;
    endproperty
    a_rx_seq: assert property (p_rx_seq) else $error("receive sequence stuck");

    property p_diag;
        @(posedge pclk) disable iff (!presetn)
        ##1 diag[DIAG_PARAM_BIT] == $past(err_param) && diag[2:0] == 3'h0 && diag[15:8] == 8'h00;
    endproperty
    a_diag: assert property (p_diag) else $error("error word wrong");

    property p_user_max;
        @(posedge pclk) disable iff (!presetn)
        go |=> tx_seg_count <= ($past(hdr_q) ? USER_BYTES_HDR2 : USER_BYTES_HDR1);
    endproperty
    a_user_max: assert property (p_user_max) else $error("too many user bytes");
endmodule
`default_nettype wire

// ==== sim/ssx_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
// Serial-side stand-in: offers received segments, logs launches and flushes
module ssx_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic offer_go,
    input wire logic [55:0] offer_data,
    input wire logic [3:0] offer_count,
    output logic rx_seg_valid,
    output logic [55:0] rx_seg_data,
    output logic [3:0] rx_seg_count,
    input wire logic rx_seg_ready,
    input wire logic tx_seg_valid,
    input wire logic [55:0] tx_seg_data,
    input wire logic [3:0] tx_seg_count,
    input wire logic [1:0] tx_seg_seq,
    input wire logic tx_flush,
    input wire logic rx_flush,
    output var int launches,
    output logic [61:0] last_tx,
    output var int tx_flushes,
    output var int rx_flushes
);
    // Offer held until taken; a slow bench simply delays offer_go
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_seg_valid <= 1'b0;
            rx_seg_data <= 56'hA5A5A5A5A5A5A5;
            rx_seg_count <= 4'hA;
            launches <= 0;
            last_tx <= 62'h0;
            tx_flushes <= 0;
            rx_flushes <= 0;
        end else begin
            if (rx_seg_valid && rx_seg_ready) begin
                // Released lines show the inverse, not a stale copy
                rx_seg_valid <= 1'b0;
                rx_seg_data <= ~rx_seg_data;
                rx_seg_count <= ~rx_seg_count;
            end else if (offer_go && !rx_seg_valid) begin
                rx_seg_valid <= 1'b1;
                rx_seg_data <= offer_data;
                rx_seg_count <= offer_count;
            end
            // Sequence logged with every launched segment
            if (tx_seg_valid) begin
                launches <= launches + 1;
                last_tx <= {tx_seg_seq, tx_seg_count, tx_seg_data};
            end
            if (tx_flush) begin
                tx_flushes <= tx_flushes + 1;
            end
            if (rx_flush) begin
                rx_flushes <= rx_flushes + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/serial_segment_exchange_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_segment_exchange_tb;
    import ssx_pkg::*;
    typedef struct {logic w; logic [7:0] idx; logic [31:0] d; logic [31:0] e; logic er;} ssx_row_type;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, offer_go;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic err_seen;
    logic [7:0] errs;
    logic [55:0] offer_data;
    logic [3:0] offer_count;
    logic rx_seg_valid, rx_seg_ready, tx_seg_valid, tx_flush, rx_flush;
    logic [55:0] rx_seg_data, tx_seg_data;
    logic [3:0] rx_seg_count, tx_seg_count;
    logic [1:0] tx_seg_seq;
    logic [61:0] last_tx;
    int launches, tx_flushes, rx_flushes, mismatches, tests_run;
    ssx_row_type rows [14];
    logic [1:0] seqs [5];

    ssx_exchange DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_seg_valid(rx_seg_valid), .rx_seg_data(rx_seg_data),
        .rx_seg_count(rx_seg_count), .rx_seg_ready(rx_seg_ready), .tx_seg_valid(tx_seg_valid),
        .tx_seg_data(tx_seg_data), .tx_seg_count(tx_seg_count), .tx_seg_seq(tx_seg_seq),
        .tx_flush(tx_flush), .rx_flush(rx_flush), .err_param(errs[3]), .err_hw(errs[4]),
        .err_handshake(errs[5]), .err_frame(errs[6]), .err_overflow(errs[7]));
    ssx_partner partner (.pclk(pclk), .presetn(presetn), .offer_go(offer_go),
        .offer_data(offer_data), .offer_count(offer_count), .rx_seg_valid(rx_seg_valid),
        .rx_seg_data(rx_seg_data), .rx_seg_count(rx_seg_count), .rx_seg_ready(rx_seg_ready),
        .tx_seg_valid(tx_seg_valid), .tx_seg_data(tx_seg_data), .tx_seg_count(tx_seg_count),
        .tx_seg_seq(tx_seg_seq), .tx_flush(tx_flush), .rx_flush(rx_flush),
        .launches(launches), .last_tx(last_tx), .tx_flushes(tx_flushes),
        .rx_flushes(rx_flushes));

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Comparison with counting
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // APB transfer: setup, access until pready, release after the taking edge
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Sampled at each rising edge; values read are those before the edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
        end
        rdata = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Offer one received segment through the partner
    task automatic offer(input logic [55:0] d, input logic [3:0] c);
        @(posedge pclk);
        offer_data <= d;
        offer_count <= c;
        offer_go <= 1'b1;
        @(posedge pclk);
        offer_go <= 1'b0;
    endtask

    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, offer_go} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        errs = 8'h00;
        offer_data = 56'h0;
        offer_count = 4'h0;
        mismatches = 0;
        tests_run = 0;
        rows = '{'{1, IDX_STAT_CLR, 32'h1, 32'h0, 0}, '{0, IDX_STAT_CLR, 32'h0, 32'h1, 0},
            '{1, IDX_TX_BYTE_COUNT, 32'h7, 32'h0, 0}, '{0, IDX_TX_BYTE_COUNT, 32'h0, 32'h7, 0},
            '{1, IDX_PAYLOAD, 32'h44332211, 32'h0, 0},
            '{0, IDX_PAYLOAD, 32'h0, 32'h44332211, 0},
            '{1, IDX_PAYLOAD_HI, 32'h00776655, 32'h0, 0}, '{0, IDX_FLUSH, 32'h0, 32'h0, 0},
            '{1, IDX_ERROR_WORD, 32'h1, 32'h0, 1}, '{0, IDX_PAYLOAD_GO, 32'h0, 32'h0, 1},
            '{0, 8'h10, 32'h0, 32'h0, 1}, '{0, IDX_ERROR_WORD, 32'h0, 32'h0, 0},
            '{0, IDX_RX_STATUS, 32'h0, 32'h0, 0}, '{0, IDX_HDR_SEL, 32'h0, 32'h0, 0}};
        seqs = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Table of plain accesses, refusals and reset values
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].idx, rows[i].d);
            check(64'(err_seen), 64'(rows[i].er));
            if (!rows[i].w) check(64'(rdata), 64'(rows[i].e));
        end
        // Launches through the full sequence cycle
        foreach (seqs[i]) begin
            apb(1, IDX_TX_SEQ, 32'(seqs[i]));
            apb(1, IDX_PAYLOAD_GO, 32'hC0DE0000 | i);
            repeat (3) @(posedge pclk);
            check(64'(launches), 64'(i + 1));
            check(64'(last_tx), 64'({seqs[i], 4'h7, 24'h776655, 32'hC0DE0000 | i}));
        end
        apb(0, IDX_RX_STATUS, 32'h0);
        check(64'(rdata & 32'h84), 64'h0);
        // Broken sequence: 2 where 1 was due
        apb(1, IDX_TX_SEQ, 32'h2);
        apb(1, IDX_PAYLOAD_GO, 32'h0);
        repeat (3) @(posedge pclk);
        apb(0, IDX_RX_STATUS, 32'h0);
        check(64'(rdata & 32'h84), 64'h84);
        // Falling clear bit, then counters frozen
        apb(1, IDX_STAT_CLR, 32'h0);
        apb(0, IDX_RX_STATUS, 32'h0);
        check(64'(rdata & 32'h84), 64'h0);
        apb(1, IDX_TX_SEQ, 32'h1);
        apb(1, IDX_TX_BYTE_COUNT, 32'h3);
        apb(0, IDX_TX_SEQ, 32'h0);
        check(64'(rdata), 64'h2);
        apb(0, IDX_TX_BYTE_COUNT, 32'h0);
        check(64'(rdata), 64'h7);
        // Flush commands, accepted then refused
        apb(1, IDX_FLUSH, 32'h1);
        repeat (2) @(posedge pclk);
        check(64'({tx_flushes[7:0], rx_flushes[7:0]}), 64'h0100);
        apb(1, IDX_FLUSH, 32'h2);
        repeat (2) @(posedge pclk);
        check(64'({tx_flushes[7:0], rx_flushes[7:0]}), 64'h0101);
        apb(1, IDX_STAT_CLR, 32'h1);
        apb(1, IDX_FLUSH, 32'h3);
        repeat (2) @(posedge pclk);
        check(64'({tx_flushes[7:0], rx_flushes[7:0]}), 64'h0101);
        // Received segment, then a second held until acknowledged
        offer(56'h77665544332211, 4'h5);
        repeat (4) @(posedge pclk);
        check(64'(rx_seg_ready), 64'h0);
        apb(0, IDX_RX_DATA_LO, 32'h0);
        check(64'(rdata), 64'h44332211);
        apb(0, IDX_RX_DATA_HI, 32'h0);
        check(64'(rdata), 64'h00776655);
        apb(0, IDX_RX_STATUS, 32'h0);
        check(64'(rdata), 64'h00050001);
        offer(56'h0E0D0C0B0A0908, 4'h7);
        repeat (6) @(posedge pclk);
        check(64'(rx_seg_valid & ~rx_seg_ready), 64'h1);
        apb(1, IDX_RX_ECHO, 32'h1);
        repeat (4) @(posedge pclk);
        apb(0, IDX_RX_STATUS, 32'h0);
        check(64'(rdata), 64'h00070002);
        // Each error input in the two-byte header mode
        apb(1, IDX_HDR_SEL, 32'h1);
        for (int b = 3; b < 8; b++) begin
            @(posedge pclk);
            errs <= 8'h01 << b;
            repeat (3) @(posedge pclk);
            apb(0, IDX_ERROR_WORD, 32'h0);
            check(64'(rdata), 64'(errs));
            apb(0, IDX_RX_STATUS, 32'h0);
            check(64'(rdata), 64'({12'h0, 4'h7, errs, 8'h82}));
        end
        // Two-byte header leaves six user bytes
        apb(1, IDX_TX_SEQ, 32'h3);
        apb(1, IDX_PAYLOAD_GO, 32'h1234ABCD);
        repeat (3) @(posedge pclk);
        check(64'(last_tx), 64'({2'h3, USER_BYTES_HDR2, 24'h776655, 32'h1234ABCD}));
        apb(1, IDX_HDR_SEL, 32'h0);
        apb(0, IDX_RX_STATUS, 32'h0);
        check(64'(rdata & 32'h0000FF00), 64'h0);
        // Mid-run reset returns outputs and registers to idle values
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check(64'({rx_seg_ready, tx_seg_valid, tx_seg_seq, tx_flush, rx_flush}), 64'h20);
        presetn <= 1'b1;
        apb(0, IDX_TX_SEQ, 32'h0);
        check(64'(rdata), 64'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
